// >>> verilog/esp_programmer.sv
// Programming station: shifts a 35-bit code into the remote-control
// part and then fires the timed enable for the high-voltage ramp.
// Assumes switch and button pins are asynchronous and bounce.
`timescale 1ns/1ns
`default_nettype none

module esp_programmer
  import esp_pkg::*;
#(
  parameter int ONESHOT_LEN = esp_pkg::ONESHOT_CYC,
  parameter int POR_LEN = esp_pkg::POR_CYC,
  parameter int DEB_LEN = esp_pkg::DEB_CYC,
  parameter int LINK_HALF_LEN = esp_pkg::LINK_HALF_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Operator inputs, high = pressed / closed
  input wire logic start_button,
  input wire logic [esp_pkg::SW_BITS-1:0] code_switches,
  // Serial link to the part
  output logic osc_resistor_pin,
  output logic code_out,
  // Programming pulse enable for the ramp generator
  output logic osc_cap_ramp_en,
  // Status
  output logic frame_active,
  output logic frame_done
);

  // ----------------------------------------------------------------
  // Input synchronisation and debounce
  // ----------------------------------------------------------------
  logic start_sync;
  logic [SW_BITS-1:0] sw_sync;
  logic start_db;
  logic [TMR_W-1:0] deb_cnt;

  esp_sync #(
    .WIDTH(SW_BITS + 1)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .pin_in({start_button, code_switches}),
    .level_out({start_sync, sw_sync})
  );

  wire deb_diff = (start_sync != start_db);
  wire deb_full = (deb_cnt == TMR_W'(DEB_LEN - 1));

  // A press is believed only after the level holds for the full window
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      deb_cnt <= '0;
      start_db <= 1'b0;
    end else if (!deb_diff) begin
      deb_cnt <= '0;
    end else if (deb_full) begin
      deb_cnt <= '0;
      start_db <= start_sync;
    end else begin
      deb_cnt <= deb_cnt + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Free-running link clock divider
  // ----------------------------------------------------------------
  logic [TMR_W-1:0] div_cnt;
  logic clk_link;

  wire div_wrap = (div_cnt == TMR_W'(LINK_HALF_LEN - 1));
  wire rise_evt = div_wrap && !clk_link;
  wire fall_evt = div_wrap && clk_link;
  wire next_clk_link = div_wrap ? !clk_link : clk_link;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      div_cnt <= '0;
      clk_link <= 1'b0;
    end else begin
      div_cnt <= div_wrap ? '0 : div_cnt + 1'b1;
      clk_link <= next_clk_link;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  esp_state_e state;
  esp_state_e next_state;
  logic [CNT_W-1:0] bit_cnt;
  logic [CNT_W-1:0] push_cnt;
  logic [CNT_W-1:0] pop_cnt;
  logic [CNT_W-1:0] cmp_value;

  for (genvar i = 0; i < CNT_W; i++) begin : g_rev
    assign cmp_value[i] = CMP_PATTERN[CNT_W-1-i];
  end

  wire match = (bit_cnt == cmp_value);
  wire shown = (pop_cnt != '0);
  wire gate = (state == ST_SHIFT);
  wire arm_go = (state == ST_ARMED) && start_db && rise_evt && shown;
  wire end_hit = gate && start_db && match;
  wire cnt_inc = rise_evt && (arm_go || (gate && !match));

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (start_db) next_state = ST_ARMED;
      end
      ST_ARMED: begin
        if (!start_db) next_state = ST_IDLE;
        else if (arm_go) next_state = ST_SHIFT;
      end
      ST_SHIFT: begin
        if (!start_db) next_state = ST_IDLE;
        else if (match) next_state = ST_DONE;
      end
      ST_DONE: begin
        if (!start_db) next_state = ST_IDLE;
      end
    endcase
  end

  wire next_gate = (next_state == ST_SHIFT);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Counter only runs while the gate passes the link clock
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bit_cnt <= '0;
    end else if (state == ST_IDLE || !start_db) begin
      bit_cnt <= '0;
    end else if (cnt_inc) begin
      bit_cnt <= bit_cnt + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Shift chain and data buffer
  // ----------------------------------------------------------------
  logic [FRAME_BITS-1:0] chain;
  logic buf_in_ready;
  logic buf_out_valid;
  logic buf_out_data;

  // Switch closed reads 1 at the pin, so the code bit is its inverse
  wire [FRAME_BITS-1:0] load_word = {RESET_PATTERN, ~sw_sync};
  wire loading = (state == ST_IDLE);
  wire push_ok = !loading && (push_cnt != CNT_W'(FRAME_BITS));
  wire do_push = push_ok && buf_in_ready;
  wire pop_win = (state == ST_ARMED) || gate;
  wire pop_req = fall_evt && pop_win && (pop_cnt != CNT_W'(FRAME_BITS));
  wire do_pop = pop_req && buf_out_valid;

  esp_buf2 #(
    .WIDTH(1),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .clk_sys(clk_sys),
    .rst(rst),
    .flush(loading),
    .in_valid(push_ok),
    .in_ready(buf_in_ready),
    .in_data(chain[FRAME_BITS-1]),
    .out_valid(buf_out_valid),
    .out_ready(pop_req),
    .out_data(buf_out_data)
  );

  // The chain stalls whenever the buffer is full
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      chain <= '0;
      push_cnt <= '0;
    end else if (loading) begin
      chain <= load_word;
      push_cnt <= '0;
    end else if (do_push) begin
      chain <= {chain[FRAME_BITS-2:0], 1'b0};
      push_cnt <= push_cnt + 1'b1;
    end
  end

  // Bits change on falling edges so they are settled at the rise
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pop_cnt <= '0;
      code_out <= 1'b0;
    end else if (loading) begin
      // Data holds on abort; clearing it could move it with clock high
      pop_cnt <= '0;
    end else if (do_pop) begin
      pop_cnt <= pop_cnt + 1'b1;
      code_out <= buf_out_data;
    end
  end

  // ----------------------------------------------------------------
  // Gated link clock and status outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      osc_resistor_pin <= 1'b0;
      frame_active <= 1'b0;
      frame_done <= 1'b0;
    end else begin
      osc_resistor_pin <= next_gate && next_clk_link;
      frame_active <= next_gate;
      frame_done <= end_hit;
    end
  end

  // ----------------------------------------------------------------
  // Power-on hold-off and programming one-shot
  // ----------------------------------------------------------------
  logic [TMR_W-1:0] por_cnt;
  logic por_done;
  logic [TMR_W-1:0] shot_cnt;

  wire por_last = (por_cnt == TMR_W'(POR_LEN - 1));
  wire [TMR_W-1:0] next_shot =
    !por_done ? '0 :
    end_hit ? TMR_W'(ONESHOT_LEN) :
    (shot_cnt != '0) ? shot_cnt - 1'b1 : '0;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      por_cnt <= '0;
      por_done <= 1'b0;
    end else if (!por_done) begin
      por_cnt <= por_cnt + 1'b1;
      por_done <= por_last;
    end
  end

  // Retriggerable like the discrete one-shot it replaces
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      shot_cnt <= '0;
      osc_cap_ramp_en <= 1'b0;
    end else begin
      shot_cnt <= next_shot;
      osc_cap_ramp_en <= (next_shot != '0);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence s_end_of_count;
    end_hit && por_done;
  endsequence

  sequence s_ramp_hold;
    osc_cap_ramp_en [*8];
  endsequence

  property p_frame_len;
    bit_cnt <= CNT_W'(FRAME_BITS);
  endproperty
  a_frame_len: assert property (p_frame_len)
    else $error("bit count ran past the frame length");

  property p_idle_clear;
    (state == ST_IDLE) |-> (bit_cnt == '0) && !osc_resistor_pin;
  endproperty
  a_idle_clear: assert property (p_idle_clear)
    else $error("idle with counter or clock active");

  property p_load;
    (state == ST_IDLE) ##1 (state == ST_IDLE) |->
      chain == {RESET_PATTERN, ~$past(sw_sync)};
  endproperty
  a_load: assert property (p_load)
    else $error("chain does not follow the switches");

  property p_arm;
    $rose(frame_active) |-> $past(rise_evt) && $past(start_db);
  endproperty
  a_arm: assert property (p_arm)
    else $error("gate opened off a link clock rise");

  property p_stop;
    (gate && match) |=> !gate ##1 !osc_resistor_pin[*4];
  endproperty
  a_stop: assert property (p_stop)
    else $error("gate stayed open at end of count");

  property p_hold;
    !start_db |=> !osc_resistor_pin && !gate;
  endproperty
  a_hold: assert property (p_hold)
    else $error("clocking without start held");

  property p_shot;
    s_end_of_count |=> s_ramp_hold;
  endproperty
  a_shot: assert property (p_shot)
    else $error("one-shot did not fire at end of count");

  property p_por;
    !por_done |-> !osc_cap_ramp_en;
  endproperty
  a_por: assert property (p_por)
    else $error("ramp enabled during power-on hold-off");

  property p_release;
    $fell(start_db) |=> (bit_cnt == '0) && (state == ST_IDLE);
  endproperty
  a_release: assert property (p_release)
    else $error("release did not return to idle");

  property p_data_edge;
    $changed(code_out) |-> !osc_resistor_pin && !clk_link;
  endproperty
  a_data_edge: assert property (p_data_edge)
    else $error("data changed while link clock high");

endmodule
`default_nettype wire

// >>> verilog/esp_pkg.sv
// Constants for the serial configuration programmer.
// Assumes a 50 MHz system clock; all timing counts derive from it.
package esp_pkg;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int FRAME_BITS = 35;
  localparam int RESET_BITS = 4;
  localparam int SEC_BITS = 22;
  localparam int CFG_BITS = 9;
  localparam int SW_BITS = SEC_BITS + CFG_BITS;
  // Lead-in pulses ahead of the switch code
  localparam logic [RESET_BITS-1:0] RESET_PATTERN = 4'hF;
  // Comparator pattern, wired to the counter in reversed bit order
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] CMP_PATTERN = 8'hC4;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int SYS_PERIOD_NS = 20;
  localparam int LINK_PERIOD_NS = 125000;
  localparam int LINK_HALF_CYC = LINK_PERIOD_NS / (2 * SYS_PERIOD_NS);
  localparam int ONESHOT_MS = 13;
  localparam int ONESHOT_CYC = ONESHOT_MS * 1000000 / SYS_PERIOD_NS;
  localparam int POR_US = 100;
  localparam int POR_CYC = POR_US * 1000 / SYS_PERIOD_NS;
  localparam int DEB_US = 5000;
  localparam int DEB_CYC = DEB_US * 1000 / SYS_PERIOD_NS;
  localparam int TMR_W = 20;
  localparam int BUF_DEPTH = 2;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ARMED,
    ST_SHIFT,
    ST_DONE
  } esp_state_e;

endpackage

// >>> verilog/esp_sync.sv
// Two-flop synchroniser for a bus of slow, independent pin levels.
// Assumes each bit is a quasi-static level; no word coherence.
`timescale 1ns/1ns
`default_nettype none
module esp_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Pins and synchronised levels
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stage1 <= '0;
      level_out <= '0;
    end else begin
      stage1 <= pin_in;
      level_out <= stage1;
    end
  end

endmodule
`default_nettype wire

// >>> verilog/esp_buf2.sv
// Small valid/ready buffer in the serial data path.
// Assumes a synchronous flush that drops all held entries.
`timescale 1ns/1ns
`default_nettype none
module esp_buf2 #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic flush,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] fill;

  wire do_wr = in_valid && in_ready;
  wire do_rd = out_valid && out_ready;
  wire [PW-1:0] wr_nxt = (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
  wire [PW-1:0] rd_nxt = (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;

  assign in_ready = (fill != (PW + 1)'(DEPTH));
  assign out_valid = (fill != '0);
  assign out_data = mem[rd_ptr];

  always_ff @(posedge clk_sys) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill <= '0;
    end else if (flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill <= '0;
    end else begin
      if (do_wr) wr_ptr <= wr_nxt;
      if (do_rd) rd_ptr <= rd_nxt;
      if (do_wr && !do_rd) fill <= fill + 1'b1;
      else if (do_rd && !do_wr) fill <= fill - 1'b1;
    end
  end

endmodule
`default_nettype wire

// >>> verif/esp_part_model.sv
// Behavioural model of the remote-control part on the programming link.
// Assumes its pins are wired straight to the programmer's outputs.
`timescale 1ns/1ns
`default_nettype none
module esp_part_model
  import esp_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Programming link
  input wire logic osc_resistor_pin,
  input wire logic code_out,
  input wire logic osc_cap_ramp_en,
  // Observation
  input wire logic clear_count,
  output logic [esp_pkg::FRAME_BITS-1:0] shift_word,
  output logic [7:0] rise_count,
  output logic [esp_pkg::FRAME_BITS-1:0] stored_word,
  output logic skew_seen
);
  import esp_pkg::*;
  logic pin_q;
  logic ramp_q;
  logic code_q;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_q <= 1'b0;
      ramp_q <= 1'b0;
      code_q <= 1'b0;
      shift_word <= '0;
      rise_count <= 8'h00;
      stored_word <= '0;
      skew_seen <= 1'b0;
    end else begin
      pin_q <= osc_resistor_pin;
      ramp_q <= osc_cap_ramp_en;
      code_q <= code_out;
      if (clear_count) begin
        rise_count <= 8'h00;
      end
      // Code taken on each rising clock
      if (osc_resistor_pin && !pin_q) begin
        shift_word <= {shift_word[FRAME_BITS-2:0], code_out};
        rise_count <= rise_count + 8'h01;
      end
      // Data moving while clock high would be mis-sampled
      if (osc_resistor_pin && pin_q && code_out !== code_q) begin
        skew_seen <= 1'b1;
      end
      // Ramp back at rest commits the shifted word
      if (!osc_cap_ramp_en && ramp_q) begin
        stored_word <= shift_word;
      end
    end
  end
endmodule
`default_nettype wire

// >>> verif/esp_programmer_tb_top.sv
// Self-checking bench for the serial configuration programmer.
// Assumes the programmer makes the link clock itself from clk_sys.
`timescale 1ns/1ns
`default_nettype none
module esp_programmer_tb_top;
  import esp_pkg::*;
  localparam int ONESHOT_SIM = 50;
  localparam int LINK_HALF_SIM = 40;
  localparam int LINK_CYC = 2 * LINK_HALF_SIM;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic start_button = 1'b0;
  logic [SW_BITS-1:0] code_switches = 31'h0000_0000;
  logic clear_count = 1'b0;
  wire logic osc_resistor_pin;
  wire logic code_out;
  wire logic osc_cap_ramp_en;
  wire logic frame_active;
  wire logic frame_done;
  wire logic [FRAME_BITS-1:0] shift_word;
  wire logic [FRAME_BITS-1:0] stored_word;
  wire logic [7:0] rise_count;
  wire logic skew_seen;
  int miscompares = 0;
  int comparisons = 0;

  esp_programmer #(.ONESHOT_LEN(ONESHOT_SIM), .POR_LEN(20), .DEB_LEN(8),
    .LINK_HALF_LEN(LINK_HALF_SIM)) dut (
    .clk_sys(clk_sys), .rst(rst), .start_button(start_button),
    .code_switches(code_switches), .osc_resistor_pin(osc_resistor_pin),
    .code_out(code_out), .osc_cap_ramp_en(osc_cap_ramp_en),
    .frame_active(frame_active), .frame_done(frame_done));
  esp_part_model part (
    .clk_sys(clk_sys), .rst(rst), .osc_resistor_pin(osc_resistor_pin),
    .code_out(code_out), .osc_cap_ramp_en(osc_cap_ramp_en),
    .clear_count(clear_count), .shift_word(shift_word),
    .rise_count(rise_count), .stored_word(stored_word),
    .skew_seen(skew_seen));

  initial begin
    forever #10 clk_sys = ~clk_sys;
  end

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  task automatic check(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic clear_model();
    clear_count = 1'b1;
    cycles(1);
    clear_count = 1'b0;
  endtask

  task test_done();
    if (miscompares == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  // Idle after power-up: no clocking, no pulse
  task automatic t_idle();
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < LINK_CYC + 500; i++) begin
      cycles(1);
      if (osc_cap_ramp_en !== 1'b0 || frame_active !== 1'b0) seen = 1'b1;
    end
    check(!seen, "activity while idle");
    check(rise_count === 8'h00, "link clock ran while idle");
  endtask

  // Release mid-frame stops everything, no programming pulse
  task automatic t_abort();
    int n;
    logic seen;
    code_switches = 31'h7FFF_FFFF;
    clear_model();
    start_button = 1'b1;
    n = 0;
    while (rise_count !== 8'h05 && n < 2 * LINK_CYC + 5 * LINK_CYC) begin
      cycles(1);
      n++;
    end
    check(rise_count === 8'h05, "abort frame never clocked");
    start_button = 1'b0;
    cycles(40);
    check(frame_active === 1'b0, "release did not stop frame");
    check(osc_resistor_pin === 1'b0, "link clock left high");
    seen = 1'b0;
    for (int i = 0; i < LINK_CYC + 500; i++) begin
      cycles(1);
      if (frame_done !== 1'b0 || osc_cap_ramp_en !== 1'b0) seen = 1'b1;
    end
    check(!seen, "pulse after abort");
    check(rise_count === 8'h05, "clocking after abort");
  endtask

  // Full frame; switches move after start and must be ignored
  task automatic t_frame(input logic [SW_BITS-1:0] sw);
    int n;
    logic [FRAME_BITS-1:0] exp_word;
    exp_word = {RESET_PATTERN, ~sw};
    code_switches = sw;
    cycles(10);
    clear_model();
    start_button = 1'b1;
    n = 0;
    while (frame_active !== 1'b1 && n < 2 * LINK_CYC + 100) begin
      cycles(1);
      n++;
    end
    check(frame_active === 1'b1, "gate never opened");
    code_switches = ~sw;
    n = 0;
    while (frame_done !== 1'b1 && n < FRAME_BITS * LINK_CYC + 100) begin
      cycles(1);
      n++;
    end
    check(frame_done === 1'b1, "no end of count");
    check(rise_count === 8'h23, "clock pulse count");
    check(shift_word === exp_word, "serial frame content");
    n = 0;
    while (osc_cap_ramp_en === 1'b1 && n < 1000) begin
      n++;
      cycles(1);
      if (n == 1) check(frame_done === 1'b0, "done not one cycle");
    end
    check(n == ONESHOT_SIM, "one-shot length");
    check(frame_active === 1'b0, "gate still open");
    cycles(LINK_CYC + 100);
    check(rise_count === 8'h23, "clocking after count");
    check(stored_word === exp_word, "committed word");
    check(skew_seen === 1'b0, "data moved while clock high");
    start_button = 1'b0;
    cycles(40);
    check(osc_cap_ramp_en === 1'b0, "pulse after release");
  endtask

  // ------------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------------
  initial begin
    cycles(20);
    rst = 1'b0;
    cycles(1);
    check(osc_cap_ramp_en === 1'b0, "ramp enable out of reset");
    t_idle();
    t_abort();
    t_frame(31'h2A5A_C31E);
    test_done();
  end

  // Whole run is near 0.1 ms; 1 ms means a hang
  initial begin
    #1000000;
    miscompares++;
    test_done();
  end
endmodule
`default_nettype wire
